// ===== logic/sas_pin_sync.sv
// Three-stage synchroniser for pin inputs; a change counts once stages two and three agree
`timescale 1ns/10ps
module sas_pin_sync
	import sas_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	// The agree test reads stages two and three, so a shorter chain cannot work
	if (WIDTH < 1 || SYNC_STAGES < 3) begin : g_bad_width
		$error("sas_pin_sync: WIDTH must be at least 1 and the chain three deep");
	end

	// ********************************************************************
	// One chain per bit
	// ********************************************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic [SYNC_STAGES-1:0] stage;

		// Stage one feeds only stage two, so metastability never reaches logic
		always_ff @(posedge clk_in) begin
			if (!rst_b_in) begin
				stage        <= '1;
				level_out[i] <= 1'b1;
			end else begin
				stage <= {stage[SYNC_STAGES-2:0], pin_in[i]};
				if (stage[1] == stage[2]) begin
					level_out[i] <= stage[2];   // Filters a single-cycle disagreement
				end
			end
		end
	end

endmodule

// ===== logic/sas_pkg.sv
// Shared constants, types and timing for the dual-port memory port controller
package sas_pkg;

	// ********************************************************************
	// Widths and mailbox words
	// ********************************************************************
	localparam int          ADDR_W         = 14;
	localparam int          DATA_W         = 16;
	localparam logic [13:0] MBOX_LEFT_ADDR  = 14'h3ffe; // Written by right port, flags left
	localparam logic [13:0] MBOX_RIGHT_ADDR = 14'h3fff; // Written by left port, flags right
	localparam int          SYNC_STAGES    = 3;
	localparam int          SYNC_LAT       = 4;          // Three stages plus the agree register
	localparam int          CNT_W          = 8;
	localparam int          CLK_PERIOD_PS  = 4000;       // 250 MHz

	// ********************************************************************
	// Pin timing in ns, fast grade then slow grade
	// ********************************************************************
	localparam int FAST_ACC_NS = 40;  // Address, chip and byte select access
	localparam int SLOW_ACC_NS = 55;
	localparam int FAST_AOE_NS = 25;  // Output drive enable access
	localparam int SLOW_AOE_NS = 30;
	localparam int FAST_HZ_NS  = 10;  // Output release
	localparam int SLOW_HZ_NS  = 25;
	localparam int FAST_RC_NS  = 40;  // Read and write cycle
	localparam int SLOW_RC_NS  = 55;
	localparam int FAST_WP_NS  = 25;  // Write pulse
	localparam int SLOW_WP_NS  = 40;
	localparam int FAST_EW_NS  = 30;  // Chip select and address to end of write
	localparam int SLOW_EW_NS  = 45;
	localparam int FAST_DW_NS  = 20;  // write_data_setup
	localparam int SLOW_DW_NS  = 30;
	localparam int FAST_WZ_NS  = 15;  // Write select to output release
	localparam int SLOW_WZ_NS  = 25;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef struct packed {
		logic chip_select_n;
		logic write_select_n;
		logic output_drive_n;
		logic upper_byte_select_n;
		logic lower_byte_select_n;
	} sas_pins_t;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        byte_en;   // [1] upper lane, [0] lower lane
	} sas_req_t;

	localparam sas_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	// Least time in ns to whole clock cycles, never below one
	function automatic int sas_min_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int sas_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

endpackage

// ===== logic/sas_port_ctrl.sv
// Host controller driving one port of an asynchronous dual-port static memory
`timescale 1ns/10ps
module sas_port_ctrl
	import sas_pkg::*;
#(
	parameter bit SLOW_GRADE = 1'b0
) (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              req_valid_in,
	input  wire sas_req_t          req_in,
	output logic                   req_ready_out,
	output logic                   rsp_valid_out,
	output logic      [DATA_W-1:0] rsp_data_out,
	output sas_pins_t              pins_out,
	output logic      [ADDR_W-1:0] addr_out,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe_n_out,
	input  wire logic              mailbox_flag_n_in,
	output logic                   mailbox_pending_out
);

	// ********************************************************************
	// Cycle counts for the chosen grade
	// ********************************************************************
	localparam int ACC_CYC = sas_max(sas_min_cyc(SLOW_GRADE ? SLOW_ACC_NS : FAST_ACC_NS),
		sas_min_cyc(SLOW_GRADE ? SLOW_AOE_NS : FAST_AOE_NS));
	localparam int HZ_CYC  = sas_min_cyc(SLOW_GRADE ? SLOW_HZ_NS : FAST_HZ_NS);
	localparam int RC_CYC  = sas_min_cyc(SLOW_GRADE ? SLOW_RC_NS : FAST_RC_NS);
	localparam int WP_CYC  = sas_min_cyc(SLOW_GRADE ? SLOW_WP_NS : FAST_WP_NS);
	localparam int EW_CYC  = sas_min_cyc(SLOW_GRADE ? SLOW_EW_NS : FAST_EW_NS);
	localparam int DW_CYC  = sas_min_cyc(SLOW_GRADE ? SLOW_DW_NS : FAST_DW_NS);
	localparam int WZDW_CYC = sas_min_cyc((SLOW_GRADE ? SLOW_WZ_NS : FAST_WZ_NS)
		+ (SLOW_GRADE ? SLOW_DW_NS : FAST_DW_NS));
	// Pulse covers the release-plus-setup case as well, so output drive may be either way
	localparam int PULSE_CYC = sas_max(sas_max(WP_CYC, WZDW_CYC), sas_max(EW_CYC, DW_CYC));
	localparam int RD_CYC    = ACC_CYC + SYNC_LAT;
	localparam int RD_GAP    = sas_max(HZ_CYC, RC_CYC - RD_CYC);
	localparam int WR_GAP    = sas_max(HZ_CYC, RC_CYC - PULSE_CYC - 2);

	if (RD_CYC >= 2 ** CNT_W || PULSE_CYC >= 2 ** CNT_W) begin : g_bad_count
		$error("sas_port_ctrl: timing counts exceed counter width");
	end

	typedef enum logic [2:0] {IDLE, RD_WAIT, WR_SETUP, WR_PULSE, WR_END, GAP} sas_state_t;

	sas_state_t        state;
	sas_state_t        next_state;
	logic [CNT_W-1:0]  cnt;
	logic [DATA_W-1:0] data_sync;
	logic              flag_sync;
	logic              take;

	assign take = (state == IDLE) && req_valid_in;

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	sas_pin_sync #(.WIDTH(DATA_W)) u_data_sync (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.pin_in    (data_in),
		.level_out (data_sync)
	);

	sas_pin_sync #(.WIDTH(1)) u_flag_sync (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.pin_in    (mailbox_flag_n_in),
		.level_out (flag_sync)
	);

	// ********************************************************************
	// Sequencer
	// ********************************************************************
	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			IDLE:     if (take) next_state = req_in.write ? WR_SETUP : RD_WAIT;
			RD_WAIT:  if (cnt == '0) next_state = GAP;
			WR_SETUP: next_state = WR_PULSE;
			WR_PULSE: if (cnt == '0) next_state = WR_END;
			WR_END:   next_state = GAP;
			GAP:      if (cnt == '0) next_state = IDLE;
		endcase
	end

	// State and the shared delay counter
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state <= IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			if (take && !req_in.write) begin
				cnt <= CNT_W'(RD_CYC - 1);
			end else if (state == WR_SETUP) begin
				cnt <= CNT_W'(PULSE_CYC - 1);
			end else if (state == RD_WAIT && cnt == '0) begin
				cnt <= CNT_W'(RD_GAP - 1);
			end else if (state == WR_END) begin
				cnt <= CNT_W'(WR_GAP - 1);
			end else if (cnt != '0) begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	// Handshake ready only in idle; registered so it comes from a flop
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			req_ready_out <= 1'b1;
		end else begin
			req_ready_out <= (next_state == IDLE);
		end
	end

	// ********************************************************************
	// Control pins
	// ********************************************************************
	// Chip select and lanes fall one cycle before write select, so write select ends first
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pins_out <= PINS_IDLE;
		end else if (take) begin
			pins_out.chip_select_n       <= 1'b0;
			pins_out.output_drive_n      <= req_in.write;
			// An empty lane mask opens both lanes rather than make a null access
			pins_out.upper_byte_select_n <= ~(req_in.byte_en[1] | ~|req_in.byte_en);
			pins_out.lower_byte_select_n <= ~(req_in.byte_en[0] | ~|req_in.byte_en);
		end else if (state == WR_SETUP) begin
			pins_out.write_select_n <= 1'b0;
		end else if (state == WR_PULSE && cnt == '0) begin
			pins_out.write_select_n <= 1'b1;
		end else if (state == WR_END || (state == RD_WAIT && cnt == '0)) begin
			pins_out <= PINS_IDLE;
		end
	end

	// Address and write data move only at take, on the edge where chip select falls, while write select is still high
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			addr_out      <= '0;
			data_out      <= '0;
			data_oe_n_out <= 1'b1;
		end else if (take) begin
			addr_out      <= req_in.addr;
			data_out      <= req_in.wdata;
			data_oe_n_out <= !req_in.write;
		end else if (state == WR_END) begin
			data_oe_n_out <= 1'b1;
		end
	end

	// ********************************************************************
	// Read answer and mailbox flag
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rsp_valid_out <= 1'b0;
			rsp_data_out  <= '0;
		end else begin
			rsp_valid_out <= (state == RD_WAIT) && (cnt == '0);
			if (state == RD_WAIT && cnt == '0) begin
				rsp_data_out <= {data_sync[15:8] & {8{!pins_out.upper_byte_select_n}},
					data_sync[7:0] & {8{!pins_out.lower_byte_select_n}}};
			end
		end
	end

	// Flag pin is active low; cleared by the device when this port reads its mailbox word
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mailbox_pending_out <= 1'b0;
		end else begin
			mailbox_pending_out <= !flag_sync;
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	logic [CNT_W-1:0] we_low_age;
	logic [CNT_W-1:0] ce_low_age;
	logic [CNT_W-1:0] addr_age;
	logic [CNT_W-1:0] drive_age;
	logic [CNT_W-1:0] oe_high_age;
	logic             addr_safe;

	// Any one of the three conditions makes an address move harmless
	assign addr_safe = pins_out.chip_select_n | pins_out.write_select_n
		| (pins_out.upper_byte_select_n & pins_out.lower_byte_select_n);

	// Saturating ages of pin conditions, read only by the checks
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			we_low_age  <= '0;
			ce_low_age  <= '0;
			addr_age    <= '0;
			drive_age   <= '0;
			oe_high_age <= '0;
		end else begin
			we_low_age  <= pins_out.write_select_n ? '0 : we_low_age + (&we_low_age ? 1'b0 : 1'b1);
			ce_low_age  <= pins_out.chip_select_n ? '0 : ce_low_age + (&ce_low_age ? 1'b0 : 1'b1);
			addr_age    <= (addr_out != $past(addr_out)) ? '0
				: addr_age + (&addr_age ? 1'b0 : 1'b1);
			drive_age   <= data_oe_n_out ? '0 : drive_age + (&drive_age ? 1'b0 : 1'b1);
			oe_high_age <= !pins_out.output_drive_n ? '0
				: oe_high_age + (&oe_high_age ? 1'b0 : 1'b1);
		end
	end

	a_addr_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!$stable(addr_out) |-> $past(addr_safe) && addr_safe)
		else $error("address moved while chip select low");
	a_write_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> $past(we_low_age) >= CNT_W'(PULSE_CYC - 1))
		else $error("write pulse too short");
	a_plain_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> $past(we_low_age) >= CNT_W'(WP_CYC - 1))
		else $error("write pulse below minimum");
	a_access_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!pins_out.write_select_n || !pins_out.output_drive_n |-> !pins_out.chip_select_n
		&& (!pins_out.upper_byte_select_n || !pins_out.lower_byte_select_n))
		else $error("access without chip select and lane");
	a_no_bus_clash: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$fell(data_oe_n_out) |-> pins_out.output_drive_n && oe_high_age >= CNT_W'(HZ_CYC))
		else $error("data driven while device may drive");
	a_ce_before_end: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> ce_low_age >= CNT_W'(EW_CYC))
		else $error("chip select too late before write end");
	a_addr_before_end: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> addr_age >= CNT_W'(EW_CYC))
		else $error("address too late before write end");
	a_data_setup: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> drive_age >= CNT_W'(DW_CYC))
		else $error("write data setup too short");
	a_data_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> !data_oe_n_out && $stable(data_out)
		##1 $rose(data_oe_n_out))
		else $error("write data not held through write end");
	a_write_recover: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pins_out.write_select_n) |-> !pins_out.chip_select_n ##1 pins_out.chip_select_n)
		else $error("write select must end write before chip select");
	a_read_answer: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		take && !req_in.write |-> ##[1:80] rsp_valid_out)
		else $error("read answer missing");

endmodule

// ===== test/sas_mem_model.sv
// Behavioural model of one port of the dual-port static memory
`timescale 1ns/10ps
module sas_mem_model
	import sas_pkg::*;
#(
	parameter int ACC_NS = FAST_ACC_NS
) (
	input  wire sas_pins_t         pins_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] ctl_data_in,
	input  wire logic              ctl_oe_n_in,
	input  wire logic              other_wr_in,
	output logic      [DATA_W-1:0] wire_out,
	output logic                   flag_n_out,
	output logic                   other_flag_n_out,
	output logic                   standby_out,
	output logic                   clash_out
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] mask, word, dq;
	logic [ADDR_W-1:0] last_addr;
	logic              rd_en, wr_en, drive;
	int                en_ns, addr_ns, off_ns;

	// ********************************************************************
	// One step per ns, half a step off the clock edges so pins have settled
	// ********************************************************************
	initial begin
		{flag_n_out, other_flag_n_out, standby_out, clash_out, drive} = 5'h1c;
		{dq, wire_out, last_addr} = '0;
		en_ns = 0;
		addr_ns = 0;
		off_ns = 0;
		#0.5;
		forever begin
			mask = {{8{~pins_in.upper_byte_select_n}}, {8{~pins_in.lower_byte_select_n}}};
			word = mem.exists(addr_in) ? mem[addr_in] : '0;
			wr_en = !pins_in.chip_select_n && !pins_in.write_select_n && mask != '0;
			rd_en = !pins_in.chip_select_n && !pins_in.output_drive_n
				&& pins_in.write_select_n && mask != '0;
			if (wr_en) mem[addr_in] = (word & ~mask) | (ctl_data_in & mask);
			if (wr_en && addr_in == MBOX_RIGHT_ADDR) other_flag_n_out = 1'b0;
			if (other_wr_in) flag_n_out = 1'b0;
			if (rd_en && addr_in == MBOX_LEFT_ADDR) flag_n_out = 1'b1;
			en_ns = rd_en ? en_ns + 1 : 0;
			addr_ns = (addr_in != last_addr) ? 1 : addr_ns + 1; // Counted like en_ns
			last_addr = addr_in;
			off_ns = pins_in.chip_select_n ? off_ns + 1 : 0;
			standby_out = (off_ns >= ACC_NS);
			// Junk before access time; unselected lanes never settle
			if (!rd_en) drive = 1'b0;
			else if (en_ns >= ACC_NS && addr_ns >= ACC_NS) begin
				dq = (word & mask) | (~dq & ~mask);
				drive = 1'b1;
			end else if (!(drive && addr_ns < 5)) begin
				drive = (en_ns >= 5);
				dq = ~dq;
			end
			if (drive && !ctl_oe_n_in) clash_out = 1'b1;
			// A released bus flips every step so stale data never reads as valid
			wire_out = !ctl_oe_n_in ? ctl_data_in : drive ? dq : ~wire_out;
			#1;
		end
	end
endmodule

// ===== test/tb.sv
// Self-checking bench for the dual-port memory port controller
`timescale 1ns/10ps
module tb;
	import sas_pkg::*;
	logic              clk_in = 1'b0;
	logic              rst_b_in = 1'b0;
	logic              req_valid_in = 1'b0;
	sas_req_t          req_in = '0;
	logic              req_ready_out, rsp_valid_out, data_oe_n_out, mailbox_pending_out;
	logic [DATA_W-1:0] rsp_data_out, data_in, data_out, pd = '0;
	logic [ADDR_W-1:0] addr_out, a = '0, wa = '0;
	sas_pins_t         pins_out, pv = PINS_IDLE;
	logic              flag_n, other_flag_n, clash, standby, poke = 1'b0;
	logic [DATA_W-1:0] exp_q[$], shadow [logic [ADDR_W-1:0]];
	logic [31:0]       seed = 32'hef2b94be;
	int                err_total = 0, total_checks = 0, cs_cnt = 0, st_cnt = 0, wp_cnt = 0;

	always #2 clk_in = ~clk_in;

	sas_port_ctrl uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_data_out(rsp_data_out), .pins_out(pins_out), .addr_out(addr_out),
		.data_in(data_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
		.mailbox_flag_n_in(flag_n), .mailbox_pending_out(mailbox_pending_out));

	sas_mem_model mem (.pins_in(pins_out), .addr_in(addr_out), .ctl_data_in(data_out),
		.ctl_oe_n_in(data_oe_n_out), .other_wr_in(poke), .wire_out(data_in),
		.flag_n_out(flag_n), .other_flag_n_out(other_flag_n), .standby_out(standby),
		.clash_out(clash));

	// ********************************************************************
	// Helpers
	// ********************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function automatic logic safe(input sas_pins_t p);
		return p.chip_select_n | p.write_select_n | (p.upper_byte_select_n & p.lower_byte_select_n);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic end_sim();
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Holds the request until ready is seen, then notes the expected answer
	task automatic issue(input logic wr, input logic [13:0] ad, input logic [15:0] wd,
		input logic [1:0] be);
		int n;
		logic [15:0] m, old;
		m = {{8{be[1] | be == 2'b00}}, {8{be[0] | be == 2'b00}}};
		old = shadow.exists(ad) ? shadow[ad] : '0;
		n = 0;
		@(posedge clk_in);
		req_valid_in <= 1'b1;
		req_in <= '{wr, ad, wd, be};
		do begin
			@(negedge clk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_total++;
			end_sim();
		end
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		if (wr) shadow[ad] = (old & ~m) | (wd & m);
		else exp_q.push_back(old & m);
	endtask

	task automatic wait_pend(input logic v);
		int n;
		for (n = 0; n < 200 && mailbox_pending_out !== v; n++) @(negedge clk_in);
		chk(mailbox_pending_out, v);
		if (n >= 200) end_sim();
	endtask

	// Read answers are matched against the oldest note
	always @(negedge clk_in) begin
		if (rsp_valid_out === 1'b1) begin
			if (exp_q.size() == 0) chk(1, 0);
			else chk(rsp_data_out, exp_q.pop_front());
		end
	end

	// Pin watcher: address changes, write strobe shape and its setup counts
	always @(negedge clk_in) begin
		if (rst_b_in && addr_out !== a) chk(safe(pv) & safe(pins_out), 1);
		if (rst_b_in && !pins_out.write_select_n)
			chk({pins_out.chip_select_n, pins_out.output_drive_n, data_oe_n_out,
				pins_out.upper_byte_select_n & pins_out.lower_byte_select_n}, 4'h4);
		if (rst_b_in && !pv.write_select_n && pins_out.write_select_n)
			chk({wp_cnt * 4 >= FAST_WP_NS, cs_cnt * 4 >= FAST_EW_NS, st_cnt * 4 >= FAST_DW_NS,
				pins_out.chip_select_n, data_oe_n_out, data_out == pd}, 6'h39);
		wp_cnt = pins_out.write_select_n ? 0 : wp_cnt + 1;
		cs_cnt = pins_out.chip_select_n ? 0 : cs_cnt + 1;
		st_cnt = (addr_out !== a || data_out !== pd) ? 0 : st_cnt + 1;
		a = addr_out;
		pd = data_out;
		pv = pins_out;
	end

	// Watchdog on the whole run
	initial begin
		repeat (60000) @(posedge clk_in);
		err_total++;
		end_sim();
	end

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		chk({pins_out, data_oe_n_out, req_ready_out, rsp_valid_out, mailbox_pending_out},
			{PINS_IDLE, 4'hc});
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			wa = (i == 0) ? 14'h0 : (i == 1) ? 14'h3ffd : seed[13:0];
			issue(1'b1, wa, seed[31:16], seed[15:14]);
			seed = xs(seed);
			// Every third read moves the address as well, so address access is timed too
			issue(1'b0, (i % 3 == 2) ? seed[15:2] : wa, '0, seed[1:0]);
		end
		issue(1'b1, MBOX_LEFT_ADDR, 16'h5aa5, 2'b11);
		@(posedge clk_in);
		poke <= 1'b1;
		@(posedge clk_in);
		poke <= 1'b0;
		wait_pend(1'b1);
		issue(1'b0, MBOX_LEFT_ADDR, '0, 2'b11);
		wait_pend(1'b0);
		issue(1'b1, MBOX_RIGHT_ADDR, 16'h0ff0, 2'b01);
		repeat (30) @(posedge clk_in);
		chk({other_flag_n, clash, standby, exp_q.size() == 0}, 4'h3);
		end_sim();
	end
endmodule
